/* File: rtl/iism_event_flag.sv */
// one raw event flag: sticky with set-over-clear, or a registered live level
`timescale 1ns/1ps
`default_nettype none
module iism_event_flag #(
  parameter bit STICKY = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  logic flag_reg;
  logic flag_next;

  // set beats a clear in the same cycle so no event is lost
  always_comb begin
    if (!STICKY) begin
      flag_next = set_in;
    end else if (set_in) begin
      flag_next = 1'b1;
    end else if (clear_in) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
  end

  // flag storage
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

endmodule : iism_event_flag
`default_nettype wire

/* File: rtl/iism_pkg.sv */
// shared constants of the i2c interrupt status and mask block
package iism_pkg;

  // register byte offsets
  localparam logic [7:0] IISM_MASKED_STATUS_OFS = 8'h2c;
  localparam logic [7:0] IISM_INTERRUPT_MASK_OFS = 8'h30;
  localparam logic [7:0] IISM_RAW_FLAGS_OFS = 8'h34;

  // bus and field geometry
  localparam int IISM_DATA_W = 32;
  localparam int IISM_EVENT_N = 14;

  // event bit positions
  localparam int IISM_RX_UNDER_BIT = 0;
  localparam int IISM_RX_OVER_BIT = 1;
  localparam int IISM_RX_FULL_BIT = 2;
  localparam int IISM_TX_OVER_BIT = 3;
  localparam int IISM_TX_EMPTY_BIT = 4;
  localparam int IISM_RD_REQ_BIT = 5;
  localparam int IISM_TX_ABORT_BIT = 6;
  localparam int IISM_RX_DONE_BIT = 7;
  localparam int IISM_ACTIVITY_BIT = 8;
  localparam int IISM_STOP_SEEN_BIT = 9;
  localparam int IISM_START_SEEN_BIT = 10;
  localparam int IISM_GENERAL_CALL_BIT = 11;
  localparam int IISM_SLAVE_RESTART_BIT = 12;
  localparam int IISM_MASTER_HOLD_BIT = 13;

  // flags that follow a live level instead of latching
  localparam logic [13:0] IISM_LEVEL_FLAGS = 14'h2114;

  // mask bits that software may always write (bits 12 and 13 depend on options)
  localparam logic [13:0] IISM_MASK_BASE_RW = 14'h0fff;

  // reset values
  localparam logic [13:0] IISM_MASK_RESET = 14'h0000;
  localparam logic [13:0] IISM_FLAGS_RESET = 14'h0000;
  localparam logic [31:0] IISM_RDATA_RESET = 32'h0000_0000;

endpackage : iism_pkg

/* File: rtl/iism_top.sv */
// interrupt status and mask registers of an i2c controller
`timescale 1ns/1ps
`default_nettype none
module iism_top
  import iism_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit DYNAMIC_TARGET_OPTION = 1'b0,
  parameter bit EMPTY_FIFO_HOLD_OPTION = 1'b0,
  parameter bit SLAVE_RESTART_DETECT_OPTION = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [IISM_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [IISM_DATA_W-1:0] reg_rdata_out,
  // events from the bus engine and fifos
  input wire logic [IISM_EVENT_N-1:0] event_in,
  input wire logic start_cond_in,
  input wire logic restart_cond_in,
  input wire logic addr_ack_in,
  input wire logic slave_mode_in,
  input wire logic ctrl_enable_in,
  input wire logic [IISM_EVENT_N-1:0] flag_clear_in,
  // combined interrupt
  output logic irq_out
);

  // elaboration check: offsets must fit the address port
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
    $error("iism_top: ADDR_W must lie between 6 and 32");
  end

  // mask bits that software may change under the chosen options
  localparam logic [13:0] MASK_WRITABLE = IISM_MASK_BASE_RW
    | ({14{DYNAMIC_TARGET_OPTION & EMPTY_FIFO_HOLD_OPTION}} & (14'h0001 << IISM_MASTER_HOLD_BIT))
    | ({14{SLAVE_RESTART_DETECT_OPTION}} & (14'h0001 << IISM_SLAVE_RESTART_BIT));

  logic [IISM_EVENT_N-1:0] mask_reg;
  logic [IISM_EVENT_N-1:0] mask_next;
  logic [IISM_EVENT_N-1:0] raw_flags;
  logic [IISM_EVENT_N-1:0] masked_status;
  logic [IISM_EVENT_N-1:0] set_vec;
  logic [IISM_EVENT_N-1:0] clear_vec;
  logic [IISM_DATA_W-1:0] rdata_reg;
  logic [IISM_DATA_W-1:0] rdata_next;
  logic irq_reg;
  logic hit_status;
  logic hit_mask;
  logic hit_raw;

  // address decode against the byte offsets
  assign hit_status = (reg_addr_in == ADDR_W'(IISM_MASKED_STATUS_OFS));
  assign hit_mask = (reg_addr_in == ADDR_W'(IISM_INTERRUPT_MASK_OFS));
  assign hit_raw = (reg_addr_in == ADDR_W'(IISM_RAW_FLAGS_OFS));

  // set conditions of each event flag
  always_comb begin
    set_vec = event_in;
    // start or restart, either role
    set_vec[IISM_START_SEEN_BIT] = start_cond_in | restart_cond_in;
    // general call address only once acknowledged
    set_vec[IISM_GENERAL_CALL_BIT] = event_in[IISM_GENERAL_CALL_BIT] & addr_ack_in;
    // event_in bit 12 is the addressed-slave level here
    set_vec[IISM_SLAVE_RESTART_BIT] = restart_cond_in & slave_mode_in
      & event_in[IISM_SLAVE_RESTART_BIT];
  end

  // sticky flags drop on their clear pulse or when the controller is disabled
  assign clear_vec = flag_clear_in | {IISM_EVENT_N{~ctrl_enable_in}};

  // one flag cell per event
  for (genvar i = 0; i < IISM_EVENT_N; i++) begin : g_flag
    iism_event_flag #(
      .STICKY(!IISM_LEVEL_FLAGS[i])
    ) u_flag (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .set_in(set_vec[i]),
      .clear_in(clear_vec[i]),
      .flag_out(raw_flags[i])
    );
  end

  // masked view: one in the mask lets the event through
  assign masked_status = raw_flags & mask_reg;

  // mask write: only the writable bits take the new value
  always_comb begin
    mask_next = mask_reg;
    if (reg_write_in && hit_mask) begin
      mask_next = (reg_wdata_in[IISM_EVENT_N-1:0] & MASK_WRITABLE)
        | (mask_reg & ~MASK_WRITABLE);
    end
  end

  // mask storage
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_reg <= IISM_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // read mux; status is read only and unmapped reads give zero
  always_comb begin
    rdata_next = IISM_RDATA_RESET;
    if (reg_read_in) begin
      if (hit_status) begin
        rdata_next[IISM_EVENT_N-1:0] = masked_status;
      end else if (hit_mask) begin
        rdata_next[IISM_EVENT_N-1:0] = mask_reg;
      end else if (hit_raw) begin
        rdata_next[IISM_EVENT_N-1:0] = raw_flags;
      end
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= IISM_RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // interrupt output, registered
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |masked_status;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign irq_out = irq_reg;

  // ---------------- assertions ----------------

  // a read of the masked status
  sequence status_read_s;
    reg_read_in && hit_status;
  endsequence

  // a mask write followed directly by a mask read
  sequence mask_write_read_s;
    (reg_write_in && hit_mask) ##1 (reg_read_in && hit_mask);
  endsequence

  // masked status shows raw and mask of the read cycle
  masked_read_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    status_read_s |=> reg_rdata_out[IISM_EVENT_N-1:0] == ($past(raw_flags) & $past(mask_reg)))
    else $error("masked status read differs from raw and mask");

  // reserved upper bits always read zero
  reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    reg_rdata_out[IISM_DATA_W-1:IISM_EVENT_N] == '0)
    else $error("reserved read bits not zero");

  // raw flags readable at their offset
  raw_read_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (reg_read_in && reg_addr_in == ADDR_W'(IISM_RAW_FLAGS_OFS))
      |=> reg_rdata_out[IISM_EVENT_N-1:0] == $past(raw_flags))
    else $error("raw flag read wrong");

  // mask written then read back through the writable bits
  mask_readback_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    mask_write_read_s |=> reg_rdata_out[IISM_EVENT_N-1:0]
      == (($past(reg_wdata_in[IISM_EVENT_N-1:0], 2) & MASK_WRITABLE)
        | ($past(mask_reg, 2) & ~MASK_WRITABLE)))
    else $error("mask read back wrong after write");

  // read-only mask bits never leave their reset value
  hold_mask_fixed_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !MASK_WRITABLE[IISM_MASTER_HOLD_BIT] |-> mask_reg[IISM_MASTER_HOLD_BIT] == IISM_MASK_RESET[IISM_MASTER_HOLD_BIT])
    else $error("master hold mask changed while read only");

  restart_mask_fixed_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !MASK_WRITABLE[IISM_SLAVE_RESTART_BIT]
      |-> mask_reg[IISM_SLAVE_RESTART_BIT] == IISM_MASK_RESET[IISM_SLAVE_RESTART_BIT])
    else $error("slave restart mask changed while read only");

  // writable option bits do take the written value
  option_bits_write_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (reg_write_in && hit_mask) |=> mask_reg[13:12]
      == (($past(reg_wdata_in[13:12]) & MASK_WRITABLE[13:12]) | ($past(mask_reg[13:12]) & ~MASK_WRITABLE[13:12])))
    else $error("option-gated mask bits wrong after write");

  // interrupt follows the OR of masked bits one cycle later
  irq_follow_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ##1 irq_out == $past(|(raw_flags & mask_reg)))
    else $error("interrupt output does not match masked flags");

  // general call flag rises only on an acknowledged general call
  general_call_flag_rise_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(raw_flags[IISM_GENERAL_CALL_BIT])
      |-> $past(event_in[IISM_GENERAL_CALL_BIT] && addr_ack_in))
    else $error("general call flag set without acknowledged call");

  // general call flag holds while enabled and not cleared
  general_call_flag_hold_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (raw_flags[IISM_GENERAL_CALL_BIT] && ctrl_enable_in && !flag_clear_in[IISM_GENERAL_CALL_BIT])
      |=> raw_flags[IISM_GENERAL_CALL_BIT])
    else $error("general call flag dropped without clear");

  // start or restart raises the start flag next cycle
  start_seen_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_cond_in || restart_cond_in) |=> raw_flags[IISM_START_SEEN_BIT])
    else $error("start seen flag missed a start");

  // slave restart only as the addressed slave
  slave_restart_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(raw_flags[IISM_SLAVE_RESTART_BIT])
      |-> $past(restart_cond_in && slave_mode_in && event_in[IISM_SLAVE_RESTART_BIT]))
    else $error("slave restart flag set outside addressed slave");

  // writing the status offset changes nothing
  status_ro_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (reg_write_in && hit_status) |=> $stable(mask_reg))
    else $error("write to masked status altered the mask");

endmodule : iism_top
`default_nettype wire

/* File: testbench/iism_bus_model.sv */
// stand-in for the i2c bus engine that raises event inputs
`timescale 1ns/1ps
`default_nettype none
module iism_bus_model
  import iism_pkg::*;
(
  input wire logic clk_sys_in,
  output logic [IISM_EVENT_N-1:0] event_out,
  output logic start_out,
  output logic restart_out,
  output logic ack_out,
  output logic slave_out
);
  // quiet bus at time zero
  initial begin
    event_out = '0;
    start_out = 1'b0;
    restart_out = 1'b0;
    ack_out = 1'b0;
    slave_out = 1'b0;
  end
  // one-cycle happening; level events and addressed-slave level stay
  task automatic happen(input logic [13:0] ev, input logic st, input logic rs, input logic ack, input logic sl);
    event_out <= ev;
    start_out <= st;
    restart_out <= rs;
    ack_out <= ack;
    slave_out <= sl;
    @(posedge clk_sys_in);
    event_out <= ev & (IISM_LEVEL_FLAGS | 14'h1000);
    start_out <= 1'b0;
    restart_out <= 1'b0;
    ack_out <= 1'b0;
  endtask : happen
endmodule : iism_bus_model
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench of the interrupt status and mask block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iism_pkg::*;
  logic clk_sys_in, arst_n_in, reg_write_in, reg_read_in, ctrl_enable_in, irq_out, rd_pend;
  logic start_cond_in, restart_cond_in, addr_ack_in, slave_mode_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, seed, m;
  logic [31:0] expq[$];
  logic [13:0] event_in, flag_clear_in;
  int bad_count, compares;

  iism_top DUT (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .event_in(event_in), .start_cond_in(start_cond_in),
    .restart_cond_in(restart_cond_in), .addr_ack_in(addr_ack_in), .slave_mode_in(slave_mode_in),
    .ctrl_enable_in(ctrl_enable_in), .flag_clear_in(flag_clear_in), .irq_out(irq_out));
  iism_bus_model peer (.clk_sys_in(clk_sys_in), .event_out(event_in), .start_out(start_cond_in),
    .restart_out(restart_cond_in), .ack_out(addr_ack_in), .slave_out(slave_mode_in));

  // free-running clock, 8 ns
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    expq.push_back(e);
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : idle
  task automatic clr(input logic [13:0] c, input logic en);
    flag_clear_in <= c;
    ctrl_enable_in <= en;
    @(posedge clk_sys_in);
    flag_clear_in <= '0;
    ctrl_enable_in <= 1'b1;
    idle(1);
  endtask : clr
  // read data watcher, compares one cycle after each read
  always @(posedge clk_sys_in) begin
    if (rd_pend && expq.size() > 0) check(reg_rdata_out, expq.pop_front());
    rd_pend <= reg_read_in;
  end
  // hang guard
  initial begin
    idle(5000);
    bad_count++;
    finish_test();
  end
  // main sequence
  initial begin
    arst_n_in = 1'b0;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    ctrl_enable_in = 1'b1;
    flag_clear_in = '0;
    seed = 32'd83988;
    idle(4);
    arst_n_in <= 1'b1;
    idle(1);
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    wr(8'h34, 32'hffff_ffff);
    wr(8'h2c, 32'hffff_ffff);
    rd(8'h30, 32'h0000_0fff);
    rd(8'h34, 32'h0);
    $display("test registers done");
    peer.happen(14'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(1);
    rd(8'h34, 32'h0400);
    rd(8'h2c, 32'h0400);
    check({31'h0, irq_out}, 32'h1);
    clr(14'h0400, 1'b1);
    peer.happen(14'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    idle(1);
    rd(8'h34, 32'h0400);
    clr(14'h0, 1'b0);
    peer.happen(14'h1000, 1'b0, 1'b1, 1'b0, 1'b1);
    idle(1);
    rd(8'h34, 32'h1400);
    rd(8'h2c, 32'h0400);
    peer.happen(14'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    clr(14'h0, 1'b0);
    $display("test start and restart done");
    peer.happen(14'h0800, 1'b0, 1'b0, 1'b0, 1'b0);
    idle(1);
    rd(8'h34, 32'h0);
    peer.happen(14'h0800, 1'b0, 1'b0, 1'b1, 1'b0);
    idle(1);
    rd(8'h34, 32'h0800);
    clr(14'h0800, 1'b1);
    rd(8'h34, 32'h0);
    peer.happen(14'h0800, 1'b0, 1'b0, 1'b1, 1'b0);
    clr(14'h0, 1'b0);
    rd(8'h34, 32'h0);
    idle(2);
    check({31'h0, irq_out}, 32'h0);
    $display("test general call done");
    peer.happen(14'h23ff, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      m = seed & 32'h0000_0fff;
      if (i == 0) m = 32'h0000_0400;
      wr(8'h30, (i == 0) ? m : seed);
      rd(8'h30, m);
      rd(8'h2c, m & 32'h23ff);
      idle(2);
      check({31'h0, irq_out}, {31'h0, |(m & 32'h23ff)});
    end
    rd(8'h34, 32'h23ff);
    idle(2);
    $display("test masking done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
